//--- rtl/pld_pkg.sv
/*
 * Constants and types for the pair control, fast link-drop and indirect
 * register access block.
 * Assumes a single 10 MHz system clock and a plain register port.
 */
package pld_pkg;

    // ************************************************************
    // Register addresses on the plain register port.
    // ************************************************************
    localparam logic [4:0] ADDR_CTRL = 5'h0b;
    localparam logic [4:0] ADDR_ICTRL = 5'h0d;
    localparam logic [4:0] ADDR_IDATA = 5'h0e;
    localparam logic [4:0] ADDR_STAT = 5'h0f;

    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int CTRL_DESCR_BIT = 10;
    localparam int CTRL_POL_BIT = 6;
    localparam int CTRL_SWAP_BIT = 5;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W = 4;
    localparam int ICTRL_CMD_LSB = 14;
    localparam int ICTRL_DEV_LSB = 0;
    localparam int DEV_W = 5;
    localparam int STAT_LSB = 4;
    localparam int CAUSE_W = 5;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] ICTRL_RESET = 16'h0000;
    localparam logic [15:0] IDATA_RESET = 16'h0000;
    localparam logic [4:0] STAT_RESET = 5'h00;

    // ************************************************************
    // Indirect access commands and device spaces.
    // ************************************************************
    typedef enum logic [1:0] {
        CMD_ADDR = 2'h0,
        CMD_DATA = 2'h1,
        CMD_DATA_INC_RW = 2'h2,
        CMD_DATA_INC_WR = 2'h3
    } pld_cmd_e;

    localparam logic [4:0] DEV_VENDOR = 5'h1f;
    localparam logic [4:0] DEV_MMD3 = 5'h03;
    localparam logic [15:0] VEND_LAST = 16'h04d1;
    localparam int VEND_DEPTH = 1234;
    localparam int MMD3_DEPTH = 64;

    // ************************************************************
    // Timing of the fast link-drop detectors.
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int WINDOW_NS = 10000;
    localparam int WINDOW_CYCLES = WINDOW_NS / CLK_PERIOD_NS;
    localparam logic [5:0] LIM_SNR = 6'h14;
    localparam logic [5:0] LIM_MLT3 = 6'h14;
    localparam logic [5:0] LIM_RXERR = 6'h20;
    localparam logic [2:0] HARDWARE_CONFIG_PIN_LOAD_CYCLE = 3'h5;

    // Detector events from the receive path, all on the system clock.
    typedef struct packed {
        logic descr_loss;
        logic energy_lost;
        logic rx_err;
        logic mlt3_err;
        logic snr_cross;
    } pld_events_s;

endpackage

//--- rtl/pld_top.sv
/*
 * Pair control, fast link-drop decision and indirect register access.
 * Assumes detector events arrive on CLK_SYS, hardware_config_pin pins are asynchronous,
 * and the register master follows the one-cycle strobe protocol.
 */
`timescale 1ns/100ps
`default_nettype none

module pld_top
    import pld_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [4:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [15:0] RDATA,
    input wire pld_events_s DROP_EVENTS,
    input wire logic EXT_PIN_MODE,
    input wire logic MII_MODE,
    input wire logic HARDWARE_CONFIG_PIN_ENERGY_DROP,
    output logic POLARITY_INVERT,
    output logic PAIR_SWAP,
    output logic LINK_DROP
);

    // ************************************************************
    // Declarations.
    // ************************************************************
    logic [15:0] ctrl_reg;
    logic [1:0] cmd_reg;
    logic [4:0] dev_reg;
    logic [15:0] vaddr_reg;
    logic [15:0] maddr_reg;
    logic [4:0] stat_reg;
    logic [4:0] stat_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic pol_reg;
    logic swap_reg;
    logic drop_reg;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync3_reg;
    logic [2:0] pin_reg;
    logic [2:0] hardware_config_pin_cnt_reg;
    logic [6:0] win_cnt_reg;
    logic win_end;
    logic [2:0] ev;
    logic [2:0] hit;
    logic [4:0] cause;
    logic dev_vendor;
    logic dev_mmd3;
    logic dev_ok;
    logic [15:0] cur_addr;
    logic in_range;
    logic data_acc;
    logic data_wr;
    logic addr_wr;
    logic post_inc;
    logic [15:0] vend_mem [0:VEND_DEPTH-1];
    logic [15:0] mmd3_mem [0:MMD3_DEPTH-1];

    // ************************************************************
    // Hardware_config_pin pins: three-stage synchroniser and agreement filter.
    // ************************************************************

    // The first stage is read only by the second stage.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
        end else begin
            sync1_reg <= {HARDWARE_CONFIG_PIN_ENERGY_DROP, MII_MODE, EXT_PIN_MODE};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A pin level is taken once the second and third stages agree.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            pin_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    pin_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    // Counts the cycles after reset release until straps are settled.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            hardware_config_pin_cnt_reg <= 3'h0;
        end else if (hardware_config_pin_cnt_reg != HARDWARE_CONFIG_PIN_LOAD_CYCLE) begin
            hardware_config_pin_cnt_reg <= hardware_config_pin_cnt_reg + 3'h1;
        end
    end

    // ************************************************************
    // Pair and link-drop control register.
    // ************************************************************

    // Software writes the writable bits; the AND of the three hardware_config_pin pins sets energy enable once.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ctrl_reg <= CTRL_RESET;
        end else if (WR_EN && ADDR == ADDR_CTRL) begin
            ctrl_reg <= 16'h0000;
            ctrl_reg[CTRL_DESCR_BIT] <= WDATA[CTRL_DESCR_BIT];
            ctrl_reg[CTRL_POL_BIT] <= WDATA[CTRL_POL_BIT];
            ctrl_reg[CTRL_SWAP_BIT] <= WDATA[CTRL_SWAP_BIT];
            ctrl_reg[CTRL_MODE_LSB +: CTRL_MODE_W] <= WDATA[CTRL_MODE_LSB +: CTRL_MODE_W];
        end else if (hardware_config_pin_cnt_reg == HARDWARE_CONFIG_PIN_LOAD_CYCLE - 3'h1) begin
            ctrl_reg[CTRL_MODE_LSB] <= pin_reg[0] & pin_reg[1] & pin_reg[2];
        end
    end

    // Pair polarity and swap controls drive the line interface.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            pol_reg <= 1'b0;
            swap_reg <= 1'b0;
        end else begin
            pol_reg <= ctrl_reg[CTRL_POL_BIT];
            swap_reg <= ctrl_reg[CTRL_SWAP_BIT];
        end
    end

    // ************************************************************
    // Fast link-drop detectors.
    // ************************************************************

    // Free-running 10us window counter.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            win_cnt_reg <= 7'h00;
        end else if (win_end) begin
            win_cnt_reg <= 7'h00;
        end else begin
            win_cnt_reg <= win_cnt_reg + 7'h01;
        end
    end

    assign win_end = (win_cnt_reg == 7'(WINDOW_CYCLES - 1));

    // Counted events: SNR crossings, line-code errors, receive errors.
    assign ev = {DROP_EVENTS.rx_err, DROP_EVENTS.mlt3_err, DROP_EVENTS.snr_cross};

    // One event counter per counted detector.
    for (genvar g = 0; g < 3; g++) begin : g_cnt
        localparam logic [5:0] LIM = (g == 0) ? LIM_SNR : ((g == 1) ? LIM_MLT3 : LIM_RXERR);
        logic [5:0] cnt_reg;

        // The count restarts at each window boundary and saturates at the limit.
        always_ff @(posedge CLK_SYS or posedge RESET) begin
            if (RESET) begin
                cnt_reg <= 6'h00;
            end else if (win_end) begin
                cnt_reg <= 6'h00;
            end else if (ev[g] && cnt_reg != LIM) begin
                cnt_reg <= cnt_reg + 6'h01;
            end
        end

        // The limit is reached by the event that brings the count to it.
        assign hit[g] = ev[g] && (cnt_reg == LIM - 6'h01);
    end

    // Each cause is gated by its enable bit.
    assign cause[0] = DROP_EVENTS.energy_lost & ctrl_reg[CTRL_MODE_LSB];
    assign cause[1] = hit[0] & ctrl_reg[CTRL_MODE_LSB + 1];
    assign cause[2] = hit[1] & ctrl_reg[CTRL_MODE_LSB + 2];
    assign cause[3] = hit[2] & ctrl_reg[CTRL_MODE_LSB + 3];
    assign cause[4] = DROP_EVENTS.descr_loss & ctrl_reg[CTRL_DESCR_BIT];

    // The link drops on any enabled cause.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            drop_reg <= 1'b0;
        end else begin
            drop_reg <= |cause;
        end
    end

    // Status bits latch each cause; a read clears them but a new cause wins.
    always_comb begin
        stat_next = stat_reg;
        if (RD_EN && ADDR == ADDR_STAT) begin
            stat_next = STAT_RESET;
        end
        stat_next = stat_next | cause;
    end

    // Status register holds the latched causes until software reads it.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            stat_reg <= STAT_RESET;
        end else begin
            stat_reg <= stat_next;
        end
    end

    // ************************************************************
    // Indirect register access.
    // ************************************************************

    // Decode of the selected device and its current address.
    assign dev_vendor = (dev_reg == DEV_VENDOR);
    assign dev_mmd3 = (dev_reg == DEV_MMD3);
    assign dev_ok = dev_vendor | dev_mmd3;
    assign cur_addr = dev_vendor ? vaddr_reg : maddr_reg;
    assign in_range = dev_vendor ? (vaddr_reg <= VEND_LAST) : (maddr_reg < 16'(MMD3_DEPTH));
    assign data_acc = (WR_EN | RD_EN) && ADDR == ADDR_IDATA && cmd_reg != CMD_ADDR && dev_ok;
    assign data_wr = data_acc & WR_EN;
    assign addr_wr = WR_EN && ADDR == ADDR_IDATA && cmd_reg == CMD_ADDR && dev_ok;
    assign post_inc = data_acc && (cmd_reg == CMD_DATA_INC_RW || (cmd_reg == CMD_DATA_INC_WR && WR_EN));

    // Indirect control register: command and device select.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            cmd_reg <= ICTRL_RESET[ICTRL_CMD_LSB +: 2];
            dev_reg <= ICTRL_RESET[ICTRL_DEV_LSB +: DEV_W];
        end else if (WR_EN && ADDR == ADDR_ICTRL) begin
            cmd_reg <= WDATA[ICTRL_CMD_LSB +: 2];
            dev_reg <= WDATA[ICTRL_DEV_LSB +: DEV_W];
        end
    end

    // Per-device address registers, loaded in address mode, advanced on CMD_DATA_INC_RW accesses and CMD_DATA_INC_WR writes.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            vaddr_reg <= IDATA_RESET;
            maddr_reg <= IDATA_RESET;
        end else if (addr_wr) begin
            if (dev_vendor) begin
                vaddr_reg <= WDATA;
            end else begin
                maddr_reg <= WDATA;
            end
        end else if (post_inc) begin
            if (dev_vendor) begin
                vaddr_reg <= vaddr_reg + 16'h0001;
            end else begin
                maddr_reg <= maddr_reg + 16'h0001;
            end
        end
    end

    // Device register storage; addresses outside a space are not written.
    always_ff @(posedge CLK_SYS) begin
        if (data_wr && in_range && dev_vendor) begin
            vend_mem[cur_addr[10:0]] <= WDATA;
        end
        if (data_wr && in_range && dev_mmd3) begin
            mmd3_mem[cur_addr[5:0]] <= WDATA;
        end
    end

    // ************************************************************
    // Read data, registered one cycle after the read strobe.
    // ************************************************************
    always_comb begin
        rdata_next = 16'h0000;
        case (ADDR)
            ADDR_CTRL: begin
                rdata_next = ctrl_reg;
            end
            ADDR_ICTRL: begin
                rdata_next[ICTRL_CMD_LSB +: 2] = cmd_reg;
                rdata_next[ICTRL_DEV_LSB +: DEV_W] = dev_reg;
            end
            ADDR_IDATA: begin
                if (!dev_ok) begin
                    rdata_next = 16'h0000;
                end else if (cmd_reg == CMD_ADDR) begin
                    rdata_next = cur_addr;
                end else if (in_range && dev_vendor) begin
                    rdata_next = vend_mem[cur_addr[10:0]];
                end else if (in_range) begin
                    rdata_next = mmd3_mem[cur_addr[5:0]];
                end
            end
            ADDR_STAT: begin
                rdata_next[STAT_LSB +: CAUSE_W] = stat_reg;
            end
            default: begin
                rdata_next = 16'h0000;
            end
        endcase
    end

    // Read data stand for one cycle only; every other cycle returns zero.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            rdata_reg <= 16'h0000;
        end else if (RD_EN) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign RDATA = rdata_reg;
    assign POLARITY_INVERT = pol_reg;
    assign PAIR_SWAP = swap_reg;
    assign LINK_DROP = drop_reg;

endmodule

`default_nettype wire

//--- verification/pld_mgmt_model.sv
/*
 * Station management model: drives the plain register port of pld_top.
 * Assumes one clock and a slave that answers reads one cycle later.
 */
`timescale 1ns/100ps
`default_nettype none
module pld_mgmt_model
    import pld_pkg::*;
(
    input wire logic clk,
    output logic [4:0] addr,
    output logic [15:0] wdata,
    output logic wr_en,
    output logic rd_en,
    input wire logic [15:0] rdata
);
    // Port starts idle at time zero.
    initial begin
        addr = 5'h00;
        wdata = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // One write cycle; returning leaves an idle edge before the next strobe.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // One read cycle; data are taken in the cycle after the strobe.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Port mirroring needs both pair bits set in the same write.
    task automatic mirror();
        wr(ADDR_CTRL, 16'h0060);
    endtask
endmodule
`default_nettype wire

//--- verification/pld_top_assertions.sv
/*
 * Checker for pld_top, watching only its ports.
 * Assumes one clock, 100-cycle detector windows from reset release.
 */
`timescale 1ns/100ps
`default_nettype none
module pld_chk
    import pld_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [4:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [15:0] RDATA,
    input wire pld_events_s DROP_EVENTS,
    input wire logic POLARITY_INVERT,
    input wire logic PAIR_SWAP,
    input wire logic LINK_DROP
);
    logic [15:0] ctl_reg;
    logic [6:0] win_reg;
    logic [6:0] rx_reg;
    logic [6:0] ml_reg;

    // Shadow of the control word and of the windowed event counts.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ctl_reg <= 16'h0000;
            win_reg <= 7'h00;
            rx_reg <= 7'h00;
            ml_reg <= 7'h00;
        end else begin
            if (WR_EN && ADDR == ADDR_CTRL) begin
                ctl_reg <= WDATA;
            end
            win_reg <= (win_reg == 7'h63) ? 7'h00 : win_reg + 7'h01;
            rx_reg <= (win_reg == 7'h63) ? 7'h00 : rx_reg + {6'h00, DROP_EVENTS.rx_err};
            ml_reg <= (win_reg == 7'h63) ? 7'h00 : ml_reg + {6'h00, DROP_EVENTS.mlt3_err};
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    sequence s_ctl_wr;
        WR_EN && ADDR == ADDR_CTRL;
    endsequence
    sequence s_quiet_rd;
        RD_EN && ADDR == ADDR_STAT && DROP_EVENTS == 5'h00;
    endsequence

    property p_pol;
        s_ctl_wr |=> ##1 POLARITY_INVERT == $past(WDATA[CTRL_POL_BIT], 2);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity output does not follow control write");
    property p_swap;
        s_ctl_wr |=> ##1 PAIR_SWAP == $past(WDATA[CTRL_SWAP_BIT], 2);
    endproperty
    a_swap: assert property (p_swap) else $error("pair swap output does not follow control write");
    property p_ictrl_rsvd;
        RD_EN && ADDR == ADDR_ICTRL |=> RDATA[13:5] == 9'h000;
    endproperty
    a_ictrl_rsvd: assert property (p_ictrl_rsvd) else $error("indirect control reserved bits read nonzero");
    property p_descr;
        DROP_EVENTS.descr_loss && ctl_reg[CTRL_DESCR_BIT] |=> LINK_DROP;
    endproperty
    a_descr: assert property (p_descr) else $error("descrambler loss did not drop link");
    property p_cause;
        LINK_DROP |-> $past(DROP_EVENTS) != 5'h00;
    endproperty
    a_cause: assert property (p_cause) else $error("link drop without any cause");
    property p_rx_lim;
        DROP_EVENTS.rx_err && rx_reg == 7'h1f && ctl_reg[3] |=> LINK_DROP;
    endproperty
    a_rx_lim: assert property (p_rx_lim) else $error("receive error limit missed");
    property p_ml_lim;
        DROP_EVENTS.mlt3_err && ml_reg == 7'h13 && ctl_reg[2] |=> LINK_DROP;
    endproperty
    a_ml_lim: assert property (p_ml_lim) else $error("line code limit missed");
    property p_stat_clr;
        (DROP_EVENTS == 5'h00) [*2] ##0 s_quiet_rd ##1 DROP_EVENTS == 5'h00 ##1 s_quiet_rd
            |=> RDATA[8:4] == 5'h00;
    endproperty
    a_stat_clr: assert property (p_stat_clr) else $error("status not cleared by read");
endmodule

bind pld_top pld_chk u_chk (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WR_EN(WR_EN),
    .RD_EN(RD_EN),
    .RDATA(RDATA),
    .DROP_EVENTS(DROP_EVENTS),
    .POLARITY_INVERT(POLARITY_INVERT),
    .PAIR_SWAP(PAIR_SWAP),
    .LINK_DROP(LINK_DROP)
);
`default_nettype wire

//--- verification/pld_top_tb.sv
/*
 * Self-checking testbench for pld_top.
 * Assumes pld_mgmt_model drives the register port and a 100 ns clock.
 */
`timescale 1ns/100ps
`default_nettype none
module pld_top_tb;
    import pld_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic ext = 1'b1;
    logic mii = 1'b1;
    logic hardware_config_pin = 1'b1;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic wr_en;
    logic rd_en;
    logic pol;
    logic swp;
    logic drop;
    pld_events_s ev = 5'h00;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int eb[5] = '{2, 1, 0, 3, 4};
    int lm[5] = '{32, 20, 20, 1, 1};
    logic [15:0] en[5] = '{16'h0008, 16'h0004, 16'h0002, 16'h0001, 16'h0400};
    logic [15:0] st[5] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0100};

    // Clock and a cycle count since reset release.
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= reset ? 0 : cyc + 1;

    pld_mgmt_model u_mgmt (.clk(clk_sys), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
    pld_top u_dut (.CLK_SYS(clk_sys), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en),
        .RDATA(rdata), .DROP_EVENTS(ev), .EXT_PIN_MODE(ext), .MII_MODE(mii), .HARDWARE_CONFIG_PIN_ENERGY_DROP(hardware_config_pin),
        .POLARITY_INVERT(pol), .PAIR_SWAP(swp), .LINK_DROP(drop));

    // ************************************************************
    // Compare and access helpers.
    // ************************************************************
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] v;
        u_mgmt.rd(a, v);
        chk16(v, exp);
    endtask
    // Reset and straps change on a rising edge; straps are stable at release.
    task automatic do_reset(input logic e, input logic m);
        @(posedge clk_sys);
        reset <= 1'b1;
        ext <= e;
        mii <= m;
        repeat (7) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic pair_chk(input logic [15:0] d);
        u_mgmt.wr(ADDR_CTRL, d);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk1(pol, d[CTRL_POL_BIT]);
        chk1(swp, d[CTRL_SWAP_BIT]);
    endtask
    // Pulses every other cycle; the link may only drop after the last one.
    task automatic pulses(input int b, input int n, input logic hit);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            ev <= pld_events_s'(5'h01 << b);
            @(posedge clk_sys);
            ev <= 5'h00;
            @(negedge clk_sys);
            chk1(drop, hit && (i == n - 1));
        end
    endtask
    // Start a burst early in a fresh detector window.
    task automatic align();
        do @(posedge clk_sys); while (cyc % 100 != 10);
    endtask
    task automatic ind_test(input logic [15:0] c);
        u_mgmt.wr(ADDR_ICTRL, c);
        u_mgmt.wr(ADDR_IDATA, 16'h0010);
        u_mgmt.wr(ADDR_ICTRL, c | 16'h8000);
        u_mgmt.wr(ADDR_IDATA, 16'ha001);
        u_mgmt.wr(ADDR_IDATA, 16'ha002);
        u_mgmt.wr(ADDR_ICTRL, c);
        rdchk(ADDR_IDATA, 16'h0012);
        u_mgmt.wr(ADDR_IDATA, 16'h0010);
        u_mgmt.wr(ADDR_ICTRL, c | 16'hc000);
        rdchk(ADDR_IDATA, 16'ha001);
        rdchk(ADDR_IDATA, 16'ha001);
        u_mgmt.wr(ADDR_IDATA, 16'hb003);
        u_mgmt.wr(ADDR_ICTRL, c | 16'h4000);
        rdchk(ADDR_IDATA, 16'ha002);
        rdchk(ADDR_IDATA, 16'ha002);
        u_mgmt.wr(ADDR_ICTRL, c | 16'h8000);
        rdchk(ADDR_IDATA, 16'ha002);
        u_mgmt.wr(ADDR_ICTRL, c);
        rdchk(ADDR_IDATA, 16'h0012);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected few thousand cycles.
    initial begin
        #5000000;
        n_mismatch++;
        tally_and_finish();
    end

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        do_reset(1'b1, 1'b1);
        rdchk(ADDR_CTRL, 16'h0001);
        do_reset(1'b0, 1'b1);
        rdchk(ADDR_CTRL, 16'h0000);
        do_reset(1'b1, 1'b0);
        rdchk(ADDR_CTRL, 16'h0000);
        rdchk(ADDR_ICTRL, 16'h0000);
        rdchk(ADDR_IDATA, 16'h0000);
        rdchk(ADDR_STAT, 16'h0000);
        u_mgmt.wr(5'h01, 16'hffff);
        rdchk(5'h01, 16'h0000);
        u_mgmt.wr(ADDR_CTRL, 16'hffff);
        rdchk(ADDR_CTRL, 16'h046f);
        u_mgmt.wr(ADDR_ICTRL, 16'hffff);
        rdchk(ADDR_ICTRL, 16'hc01f);
        $display("test registers done");
        u_mgmt.mirror();
        pair_chk(16'h0060);
        pair_chk(16'h0040);
        pair_chk(16'h0020);
        pair_chk(16'h0000);
        $display("test pairs done");
        ind_test({11'h000, DEV_VENDOR});
        ind_test({11'h000, DEV_MMD3});
        u_mgmt.wr(ADDR_ICTRL, 16'h4007);
        u_mgmt.wr(ADDR_IDATA, 16'hbeef);
        rdchk(ADDR_IDATA, 16'h0000);
        u_mgmt.wr(ADDR_ICTRL, 16'h0007);
        u_mgmt.wr(ADDR_IDATA, 16'h0030);
        u_mgmt.wr(ADDR_ICTRL, 16'h0003);
        rdchk(ADDR_IDATA, 16'h0012);
        for (int j = 0; j < 2; j++) begin
            u_mgmt.wr(ADDR_ICTRL, 16'h001f);
            u_mgmt.wr(ADDR_IDATA, VEND_LAST + 16'(1 - j));
            u_mgmt.wr(ADDR_ICTRL, 16'h401f);
            u_mgmt.wr(ADDR_IDATA, 16'h5555);
            rdchk(ADDR_IDATA, (j == 1) ? 16'h5555 : 16'h0000);
        end
        $display("test indirect done");
        for (int k = 0; k < 5; k++) begin
            u_mgmt.wr(ADDR_CTRL, 16'h0000);
            align();
            pulses(eb[k], lm[k], 1'b0);
            u_mgmt.wr(ADDR_CTRL, en[k]);
            align();
            pulses(eb[k], lm[k] - 1, 1'b0);
            align();
            pulses(eb[k], lm[k], 1'b1);
            rdchk(ADDR_STAT, st[k]);
            rdchk(ADDR_STAT, 16'h0000);
        end
        $display("test link drop done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
